/* shared/cpmc_cfg.svh */
/*
 * Constants of the power-mode controller: offsets, fields, resets, timing.
 * Assumes inclusion by bare name from the design module and the testbench.
 */
`ifndef CPMC_CFG_SVH
`define CPMC_CFG_SVH
// ****************************************************************
// Register offsets (byte addresses, one word each)
// ****************************************************************
`define CPMC_OFS_PWR 4'h0
`define CPMC_OFS_CFG 4'h4
`define CPMC_OFS_STAT 4'h8
// ****************************************************************
// Field positions
// ****************************************************************
`define CPMC_PWR_IDLE 0
`define CPMC_PWR_STOP 1
`define CPMC_CFG_WDT 0
`define CPMC_CFG_LCD 1
`define CPMC_CFG_SUSP 2
`define CPMC_CFG_ZTC 3
`define CPMC_ST_WDT 4
`define CPMC_ST_LCD 5
`define CPMC_ST_EXT 6
// ****************************************************************
// Reset values and timing
// ****************************************************************
`define CPMC_CFG_RST 4'h0
`define CPMC_RST_VECTOR 16'h0000
`define CPMC_LCD_TIMEOUT_US 100
`define CPMC_CLK_MHZ 100
`define CPMC_LCD_CYC (`CPMC_LCD_TIMEOUT_US * `CPMC_CLK_MHZ)
`define CPMC_RSTSEQ_CYC 4
`endif

/* shared/cpmc_pkg.sv */
/*
 * Types of the power-mode controller.
 * Assumes cpmc_cfg.svh on the include path.
 */
package cpmc_pkg;
  // Operating modes of the core
  typedef enum logic [2:0] {
    CPMC_RUN, CPMC_IDLE, CPMC_STOP, CPMC_SUSP, CPMC_RSTSEQ
  } cpmc_mode_t;
  // Clock and activity gates driven to the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic int_osc_en;
    logic irq_timer_en;
    logic lcd_active;
  } cpmc_gate_t;
endpackage : cpmc_pkg

/* rtl/cpmc_power_ctrl.sv */
/*
 * Power-mode controller: idle, stop and suspend sequencing with an
 * AXI4-Lite register slave and reset sequencing.
 * Assumes one clock, synchronous inputs, and a CPU that pulses instr_done
 * when each instruction retires.
 */
// Operation
// - Idle bit halts CPU after writing instruction
// - Idle keeps clocks and peripherals running
// - Registers and memory kept across idle
// - Enabled interrupt clears idle, resumes CPU
// - After return, continue past idle-setting instruction
// - Reset ends idle, fetch from 0x0000
// - Enabled watchdog expiry resets out of idle
// - Stop bit enters stop after instruction
// - Stop halts oscillator, CPU, digital peripherals
// - Stop disables interrupts, timers, except detector
// - Only reset exits stop, fetch 0x0000
// - Lost-clock detector resets after 100 us
// - Oscillators off in stop needs reset to restart
// - Suspend halts oscillator until wake event
// - Mode-select bits always read zero
`timescale 1ns/10ps
`include "cpmc_cfg.svh"
module cpmc_power_ctrl import cpmc_pkg::*; #(
  parameter int LCD_CYC = `CPMC_LCD_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire logic wdt_expire,
  input wire logic ext_reset,
  input wire logic wake_event,
  output cpmc_gate_t gate,
  output logic core_reset,
  output logic [15:0] fetch_addr,
  output logic irq_resume,
  output logic ref_zero_tempco_enable,
  output cpmc_mode_t mode
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  localparam int CW = $clog2(LCD_CYC + 1);
  logic aw_full; // Write address held
  logic w_full; // Write data held
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic do_wr; // Both halves present, response slot free
  logic [1:0] mode_sel; // Latched idle/stop request
  logic [3:0] cfg; // Software configuration
  logic [2:0] rst_cause; // Last reset source
  logic [CW-1:0] lcd_cnt;
  logic lcd_fire;
  logic wdt_fire;
  logic any_rst;
  logic [2:0] seq_cnt;
  cpmc_mode_t next_mode;

  // Gates per mode; shared by the output register's reset and update paths
  function automatic cpmc_gate_t gate_of(input cpmc_mode_t m);
    cpmc_gate_t g;
    g = '{default: 1'b1};
    unique case (m)
      CPMC_RUN: g = g;
      CPMC_IDLE: g.cpu_clk_en = 1'b0;
      CPMC_STOP: g = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      CPMC_SUSP: g = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      CPMC_RSTSEQ: g = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    endcase
    return g;
  endfunction : gate_of

  // ****************************************************************
  // AXI4-Lite write path
  // ****************************************************************
  assign s_awready = !aw_full;
  assign s_wready = !w_full;
  assign do_wr = aw_full && w_full && !s_bvalid;

  // Address and data may arrive in either order
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      aw_full <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_awvalid && s_awready) begin
      aw_full <= 1'b1;
      aw_addr <= s_awaddr;
    end else if (do_wr) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_lane0 <= 1'b0;
    end else if (s_wvalid && s_wready) begin
      w_full <= 1'b1;
      w_data <= s_wdata;
      w_lane0 <= s_wstrb[0];
    end else if (do_wr) begin
      w_full <= 1'b0;
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_bvalid <= 1'b0;
      s_bresp <= 2'h0;
    end else if (do_wr) begin
      s_bvalid <= 1'b1;
      s_bresp <= (aw_addr == `CPMC_OFS_PWR || aw_addr == `CPMC_OFS_CFG ||
                  aw_addr == `CPMC_OFS_STAT) ? 2'h0 : 2'h2;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // Configuration survives idle and internal resets alike
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cfg <= `CPMC_CFG_RST;
    end else if (do_wr && w_lane0 && aw_addr == `CPMC_OFS_CFG) begin
      cfg <= w_data[3:0];
    end else if (mode == CPMC_SUSP) begin
      cfg[`CPMC_CFG_SUSP] <= 1'b0; // Suspend request self-clears
    end
  end
  assign ref_zero_tempco_enable = cfg[`CPMC_CFG_ZTC];

  // ****************************************************************
  // AXI4-Lite read path
  // ****************************************************************
  assign s_arready = !s_rvalid;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= 2'h0;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rresp <= 2'h0;
      unique case (s_araddr)
        `CPMC_OFS_PWR: s_rdata <= 32'h0000_0000;
        `CPMC_OFS_CFG: s_rdata <= {28'h0000000, cfg};
        `CPMC_OFS_STAT: s_rdata <= {25'h0000000, rst_cause, 1'b0, mode};
        default: begin
          s_rdata <= 32'h0000_0000;
          s_rresp <= 2'h2; // Unmapped address
        end
      endcase
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Mode selection and reset sources
  // ****************************************************************
  // Requests only count while the CPU runs; any reset drops them
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_sel <= 2'h0;
    end else if (any_rst || mode == CPMC_RSTSEQ) begin
      mode_sel <= 2'h0;
    end else if (mode != CPMC_RUN) begin
      mode_sel <= 2'h0;
    end else if (do_wr && w_lane0 && aw_addr == `CPMC_OFS_PWR) begin
      mode_sel <= mode_sel | w_data[1:0];
    end
  end

  assign wdt_fire = wdt_expire && cfg[`CPMC_CFG_WDT] && mode != CPMC_STOP;
  assign lcd_fire = lcd_cnt == CW'(LCD_CYC - 1);
  assign any_rst = wdt_fire || lcd_fire || ext_reset;

  // Detector runs only in stop, where the clock would be missing
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lcd_cnt <= '0;
    end else if (mode == CPMC_STOP && cfg[`CPMC_CFG_LCD] && !lcd_fire) begin
      lcd_cnt <= lcd_cnt + CW'(1);
    end else begin
      lcd_cnt <= '0;
    end
  end

  // Remember the source for software after restart
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rst_cause <= 3'h0;
    end else if (any_rst && mode != CPMC_RSTSEQ) begin
      rst_cause <= {ext_reset, lcd_fire, wdt_fire};
    end
  end

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  always_comb begin
    next_mode = mode;
    unique case (mode)
      CPMC_RUN: begin
        if (any_rst) next_mode = CPMC_RSTSEQ;
        else if (instr_done && mode_sel[`CPMC_PWR_STOP]) next_mode = CPMC_STOP;
        else if (instr_done && mode_sel[`CPMC_PWR_IDLE]) next_mode = CPMC_IDLE;
        else if (cfg[`CPMC_CFG_SUSP]) next_mode = CPMC_SUSP;
      end
      CPMC_IDLE: begin
        if (any_rst) next_mode = CPMC_RSTSEQ;
        else if (irq_pending) next_mode = CPMC_RUN;
      end
      CPMC_STOP: begin
        if (any_rst) next_mode = CPMC_RSTSEQ;
      end
      CPMC_SUSP: begin
        if (any_rst) next_mode = CPMC_RSTSEQ;
        else if (wake_event) next_mode = CPMC_RUN;
      end
      CPMC_RSTSEQ: begin
        if (seq_cnt == 3'(`CPMC_RSTSEQ_CYC - 1)) next_mode = CPMC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode <= CPMC_RSTSEQ;
    end else begin
      mode <= next_mode;
    end
  end

  // Reset sequence length counter
  always_ff @(posedge clk_sys) begin
    if (!rstn || mode != CPMC_RSTSEQ) begin
      seq_cnt <= 3'h0;
    end else begin
      seq_cnt <= seq_cnt + 3'h1;
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      gate <= gate_of(CPMC_RSTSEQ);
      core_reset <= 1'b1;
    end else begin
      gate <= gate_of(next_mode);
      core_reset <= next_mode == CPMC_RSTSEQ;
    end
  end

  // Program counter load: vector after reset; idle exit leaves PC alone
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fetch_addr <= `CPMC_RST_VECTOR;
      irq_resume <= 1'b0;
    end else begin
      irq_resume <= mode == CPMC_IDLE && next_mode == CPMC_RUN;
      if (next_mode == CPMC_RSTSEQ) fetch_addr <= `CPMC_RST_VECTOR;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_idle_req;
    mode == CPMC_RUN && mode_sel == 2'h1 && instr_done && !any_rst;
  endsequence
  // Gates are registered from the next state, so they change on the same edge as mode
  sequence s_idle_held;
    mode == CPMC_IDLE && !gate.cpu_clk_en && gate.periph_clk_en;
  endsequence

  chk_idle_entry: assert property (s_idle_req |=> s_idle_held)
    else $error("idle not entered after instruction");
  chk_stop_prio: assert property (
    mode == CPMC_RUN && mode_sel[1] && instr_done && !any_rst |=> mode == CPMC_STOP)
    else $error("stop not taken");
  chk_idle_wake: assert property (
    mode == CPMC_IDLE && irq_pending && !any_rst |=> mode == CPMC_RUN && irq_resume)
    else $error("interrupt did not end idle");
  chk_stop_hold: assert property (
    mode == CPMC_STOP && !any_rst |=> mode == CPMC_STOP && !gate.int_osc_en)
    else $error("stop left without reset");
  chk_rst_vector: assert property (
    any_rst && mode != CPMC_RSTSEQ |=> mode == CPMC_RSTSEQ && core_reset && fetch_addr == 16'h0000)
    else $error("reset sequence wrong");
  chk_lcd_fire: assert property (
    mode == CPMC_STOP && cfg[1] && lcd_cnt == CW'(LCD_CYC - 2) && !ext_reset |=> ##1 mode == CPMC_RSTSEQ)
    else $error("detector timeout missed");
  chk_mode_read: assert property (
    s_arvalid && s_arready && s_araddr == 4'h0 |=> s_rdata == 32'h0000_0000)
    else $error("mode bits read nonzero");
  chk_susp_wake: assert property (
    mode == CPMC_SUSP && !wake_event && !any_rst |=> mode == CPMC_SUSP)
    else $error("suspend left without wake");
  chk_rst_clear: assert property (mode == CPMC_RSTSEQ |=> mode_sel == 2'h0)
    else $error("mode bits survive reset");
endmodule : cpmc_power_ctrl

/* verification/tb.sv */
/*
 * Self-checking bench of the power-mode controller: AXI4-Lite tasks and mode sequences.
 * Assumes cpmc_pkg compiled first and cpmc_cfg.svh on the include path.
 */
`timescale 1ns/10ps
`include "cpmc_cfg.svh"
module tb import cpmc_pkg::*;;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rd;
  logic awready, wready, bvalid, arready, rvalid, core_reset, irq_resume, ztc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic instr_done = 1'b0, irq_pending = 1'b0, wdt_expire = 1'b0, ext_reset = 1'b0, wake_event = 1'b0;
  logic [15:0] fetch_addr;
  cpmc_gate_t gate;
  cpmc_mode_t mode;
  int n_fail = 0, comparisons = 0, cycles = 0;
  // Short detector count keeps the stop tests brief
  localparam int LCD = 16;
  always #5 clk_sys = ~clk_sys;
  cpmc_power_ctrl #(.LCD_CYC(LCD)) i_cpmc_power_ctrl (.clk_sys(clk_sys), .rstn(rstn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready), .instr_done(instr_done), .irq_pending(irq_pending),
    .wdt_expire(wdt_expire), .ext_reset(ext_reset), .wake_event(wake_event), .gate(gate),
    .core_reset(core_reset), .fetch_addr(fetch_addr), .irq_resume(irq_resume),
    .ref_zero_tempco_enable(ztc), .mode(mode));
  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ****************************************************************
  // Bus and mode tasks
  // ****************************************************************
  // Ready is looked at on the falling edge; it holds to the next rising edge
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, done;
    int t;
    done = 1'b0;
    t = 0;
    @(posedge clk_sys);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
    while (!done && t < 100) begin
      @(negedge clk_sys);
      ha = awvalid && awready;
      hw = wvalid && wready;
      done = bvalid;
      if (done) chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clk_sys);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
      t++;
    end
    if (!done) chk("write timeout", 32'h1, 32'h0);
  endtask : axw
  task automatic axr(input logic [3:0] a, input logic [1:0] er, output logic [31:0] d);
    logic ha, done;
    int t;
    done = 1'b0;
    t = 0;
    d = 32'h0;
    @(posedge clk_sys);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!done && t < 100) begin
      @(negedge clk_sys);
      ha = arvalid && arready;
      done = rvalid;
      if (done) d = rdata;
      if (done) chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge clk_sys);
      if (ha) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
      t++;
    end
    if (!done) chk("read timeout", 32'h1, 32'h0);
  endtask : axr
  // Bounded wait for a mode code, then one compare
  task automatic wait_mode(input cpmc_mode_t m, input int n);
    int t;
    t = 0;
    do begin
      @(negedge clk_sys);
      t++;
    end while (mode !== m && t < n);
    chk("mode", 32'(m), 32'(mode));
  endtask : wait_mode
  task automatic retire();
    @(posedge clk_sys) instr_done <= 1'b1;
    @(posedge clk_sys) instr_done <= 1'b0;
  endtask : retire
  // Reset sequence ended: running, fetch from the vector, reset released
  task automatic back_to_run();
    wait_mode(CPMC_RUN, 40);
    @(negedge clk_sys);
    chk("core_reset", 32'h0, {31'h0, core_reset});
    chk("fetch_addr", {16'h0, `CPMC_RST_VECTOR}, {16'h0, fetch_addr});
  endtask : back_to_run
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    back_to_run();
    axr(`CPMC_OFS_CFG, 2'b00, rd); chk("cfg reset", 32'h0, rd);
    // Idle entry with zero-tempco kept as a marker of register contents
    axw(`CPMC_OFS_CFG, 32'h8, 2'b00);
    axw(`CPMC_OFS_PWR, 32'h1, 2'b00);
    retire();
    wait_mode(CPMC_IDLE, 10);
    chk("idle gates", 32'h7, {28'h0, gate[4:1]});
    axr(`CPMC_OFS_PWR, 2'b00, rd); chk("pwr reads zero", 32'h0, rd);
    axr(`CPMC_OFS_CFG, 2'b00, rd); chk("cfg in idle", 32'h8, rd);
    @(posedge clk_sys) irq_pending <= 1'b1;
    wait_mode(CPMC_RUN, 10);
    // Resume pulse stands only in the first cycle back in run
    chk("irq_resume", 32'h1, {31'h0, irq_resume});
    chk("no reset on resume", 32'h0, {31'h0, core_reset});
    @(posedge clk_sys) irq_pending <= 1'b0;
    chk("ztc kept", 32'h1, {31'h0, ztc});
    // Watchdog expiry ends idle through a reset
    axw(`CPMC_OFS_CFG, 32'h1, 2'b00);
    axw(`CPMC_OFS_PWR, 32'h1, 2'b00);
    retire();
    wait_mode(CPMC_IDLE, 10);
    @(posedge clk_sys) wdt_expire <= 1'b1;
    @(posedge clk_sys) wdt_expire <= 1'b0;
    wait_mode(CPMC_RSTSEQ, 10);
    chk("core_reset", 32'h1, {31'h0, core_reset});
    back_to_run();
    axr(`CPMC_OFS_STAT, 2'b00, rd); chk("cause wdt", 32'h10, rd & 32'h17);
    // Both bits: stop; interrupts and watchdog do not end it
    axw(`CPMC_OFS_CFG, 32'h1, 2'b00);
    axw(`CPMC_OFS_PWR, 32'h3, 2'b00);
    retire();
    wait_mode(CPMC_STOP, 10);
    chk("stop gates", 32'h0, {28'h0, gate[4:1]});
    @(posedge clk_sys) irq_pending <= 1'b1;
    wdt_expire <= 1'b1;
    repeat (3 * LCD) @(posedge clk_sys);
    irq_pending <= 1'b0;
    wdt_expire <= 1'b0;
    @(negedge clk_sys);
    chk("stop holds", 32'(CPMC_STOP), 32'(mode));
    @(posedge clk_sys) ext_reset <= 1'b1;
    @(posedge clk_sys) ext_reset <= 1'b0;
    back_to_run();
    retire();
    repeat (3) @(negedge clk_sys);
    chk("bits cleared", 32'(CPMC_RUN), 32'(mode));
    // Detector ends stop after its count, not before
    axw(`CPMC_OFS_CFG, 32'h2, 2'b00);
    axw(`CPMC_OFS_PWR, 32'h2, 2'b00);
    retire();
    wait_mode(CPMC_STOP, 10);
    chk("detector live", 32'h1, {31'h0, gate.lcd_active});
    repeat (LCD - 6) @(negedge clk_sys);
    chk("no early reset", 32'(CPMC_STOP), 32'(mode));
    wait_mode(CPMC_RSTSEQ, 14);
    back_to_run();
    axr(`CPMC_OFS_STAT, 2'b00, rd); chk("cause lcd", 32'h20, rd & 32'h27);
    // Suspend with zero-tempco set first, ended by a wake event
    axw(`CPMC_OFS_CFG, 32'h8, 2'b00);
    axw(`CPMC_OFS_CFG, 32'hC, 2'b00);
    retire();
    wait_mode(CPMC_SUSP, 10);
    chk("osc halted", 32'h0, {31'h0, gate.int_osc_en});
    repeat (5) @(negedge clk_sys);
    chk("suspend holds", 32'(CPMC_SUSP), 32'(mode));
    @(posedge clk_sys) wake_event <= 1'b1;
    wait_mode(CPMC_RUN, 10);
    @(posedge clk_sys) wake_event <= 1'b0;
    // Unmapped word answers with a slave error
    axr(4'hC, 2'b10, rd);
    axw(4'hC, 32'h1, 2'b10);
    tally_and_finish();
  end
endmodule : tb
